// ==== design/qwh_core.sv ====
// queue write-back and hint configuration: apb registers, head write-back
// engine, launch time adder and receive hint lookup.
// assumes all queue events come from logic on pclk, one-cycle pulses.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

// How it works
// - head write-back on writes completed head to memory; off means never
// - head write-back on blocks soft flush and all descriptor write-backs
// - with expiry bit set, throttle timer expiry causes a head write-back
// - low word gives address 31:3; target bits 2:0 forced to zero
// - high word gives upper 32 address bits above the low word
// - four low/high address pairs at 0xE038 plus 0x40 per queue
// - low address words also reachable at legacy alias offsets
// - high address words also reachable at legacy alias offsets
// - launch base is bits 29:5 in 32 ns units
// - launch time equals base plus the packet's relative launch time
// - four receive hint control registers at 0xC014 plus 0x40 per queue
// - bit 0 enables hints on receive descriptor fetches
// - bit 1 enables hints on receive descriptor write-backs
// - bit 2 enables hints on received header writes
// - bit 3 enables hints on received payload writes
// - hinted writes take hint value from the target hint field
// - receive data write is no-snoop only when descriptor select bit set
module qwh_core
  import qwh_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [15:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // transmit queue events
  input  wire logic [NQ-1:0]          tx_desc_done,
  input  wire logic [NQ-1:0]          throttle_expired,
  input  wire logic [NQ-1:0]          soft_flush_request,
  input  wire logic [NQ*HEAD_W-1:0]   tx_head_index,
  output logic      [NQ-1:0]          desc_wb_allow,
  output logic      [NQ-1:0]          flush_take,
  // head write-back dma request
  output logic                        dma_wr_valid,
  input  wire logic                   dma_wr_ready,
  output logic      [63:0]            dma_wr_addr,
  output logic      [31:0]            dma_wr_data,
  // launch time
  input  wire logic                   launch_req,
  input  wire logic [LREL_W-1:0]      launch_rel,
  output logic                        launch_valid,
  output logic      [31:0]            launch_time_ns,
  // receive hint lookup
  input  wire logic                   rx_req,
  input  wire logic [1:0]             rx_req_kind,
  input  wire logic [1:0]             rx_req_queue,
  input  wire logic                   rx_req_nse,
  output logic                        rx_resp_valid,
  output logic                        rx_hint_on,
  output logic      [QWH_HINT_W-1:0]  rx_hint_value,
  output logic                        rx_no_snoop
);

  // decode result: hit, register group, queue
  typedef struct packed {
    logic     hit;
    qwh_reg_t grp;
    logic [1:0] q;
  } qwh_dec_t;

  // address decode, shared by read and write paths
  function automatic qwh_dec_t qwh_decode(input logic [15:0] a);
    qwh_dec_t d;
    d.hit = 1'b0;
    d.grp = QWH_REG_LAUNCH;
    d.q   = 2'h0;
    if (a == QWH_LAUNCH_OFS) begin
      d.hit = 1'b1;
    end
    for (int i = 0; i < NQ; i++) begin
      if (a == QWH_COMP_LO_OFS + 16'(i) * QWH_QUEUE_STRIDE ||
          a == QWH_COMP_LO_ALIAS + 16'(i) * QWH_ALIAS_STRIDE) begin
        d.hit = 1'b1;
        d.grp = QWH_REG_COMP_LO;
        d.q   = 2'(i);
      end
      if (a == QWH_COMP_HI_OFS + 16'(i) * QWH_QUEUE_STRIDE ||
          a == QWH_COMP_HI_ALIAS + 16'(i) * QWH_ALIAS_STRIDE) begin
        d.hit = 1'b1;
        d.grp = QWH_REG_COMP_HI;
        d.q   = 2'(i);
      end
      if (a == QWH_RX_QUEUE_HINT_CONTROL_OFS + 16'(i) * QWH_QUEUE_STRIDE) begin
        d.hit = 1'b1;
        d.grp = QWH_REG_RX_QUEUE_HINT_CONTROL;
        d.q   = 2'(i);
      end
    end
    return d;
  endfunction

  // register storage
  // flops indexed by queue; aliases decode onto the same index
  logic [31:0] comp_lo_r [NQ];
  logic [31:0] comp_hi_r [NQ];
  logic [31:0] rx_queue_hint_control_r   [NQ];
  logic [31:0] launch_r;

  // decode result and apb strobes
  qwh_dec_t    dec;
  logic        setup;
  logic        wr_fire;
  logic [31:0] rd_nxt;

  // a write lands only on the edge that sees pready high
  assign dec     = qwh_decode(paddr);
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;

  // read mux; the low word reads back its enable bits in 1:0 as written
  always_comb begin
    rd_nxt = QWH_ZERO32;
    if (dec.hit) begin
      case (dec.grp)
        QWH_REG_COMP_LO: rd_nxt = comp_lo_r[dec.q];
        QWH_REG_COMP_HI: rd_nxt = comp_hi_r[dec.q];
        QWH_REG_LAUNCH:  rd_nxt = launch_r;
        QWH_REG_RX_QUEUE_HINT_CONTROL:   rd_nxt = rx_queue_hint_control_r[dec.q];
        default:         rd_nxt = QWH_ZERO32;
      endcase
    end
  end

  // apb answer: registered in setup, one access cycle, no wait states
  // unmapped addresses answer with pslverr and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= QWH_ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? QWH_ZERO32 : rd_nxt;
        pslverr <= ~dec.hit;                     // unmapped address errors
      end else if (pready) begin
        prdata  <= QWH_ZERO32;
        pslverr <= 1'b0;
      end
    end
  end

  // per-queue storage; aliases resolve to the same flops
  generate
    for (genvar g = 0; g < NQ; g++) begin : g_q
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          comp_lo_r[g] <= QWH_ZERO32;
          comp_hi_r[g] <= QWH_ZERO32;
          rx_queue_hint_control_r[g]   <= QWH_ZERO32;
        end else if (wr_fire && dec.hit && dec.q == 2'(g)) begin
          if (dec.grp == QWH_REG_COMP_LO) begin
            comp_lo_r[g] <= {pwdata[31:2], pwdata[1:0]};
          end
          if (dec.grp == QWH_REG_COMP_HI) begin
            comp_hi_r[g] <= pwdata;
          end
          if (dec.grp == QWH_REG_RX_QUEUE_HINT_CONTROL) begin
            rx_queue_hint_control_r[g] <= pwdata & QWH_RX_QUEUE_HINT_CONTROL_MASK;
          end
        end
      end
    end
  endgenerate

  // launch base; bit 31 comes up set and keeps what software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_r <= QWH_LAUNCH_RST;
    end else if (wr_fire && dec.hit && dec.grp == QWH_REG_LAUNCH) begin
      launch_r <= pwdata;
    end
  end

  // per-queue mode decode
  logic [NQ-1:0] hwb_on;
  logic [NQ-1:0] expiry_on;
  generate
    for (genvar g = 0; g < NQ; g++) begin : g_mode
      assign hwb_on[g]    = comp_lo_r[g][QWH_HEAD_WB_ON_BIT];
      assign expiry_on[g] = comp_lo_r[g][QWH_WB_EXPIRY_BIT];
    end
  endgenerate

  // descriptor write-back and soft flush are suppressed in head mode
  // registered, so queue logic sees a mode change one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_wb_allow <= '0;
      flush_take    <= '0;
    end else begin
      desc_wb_allow <= ~hwb_on;
      flush_take    <= soft_flush_request & ~hwb_on;
    end
  end

  // pending head write-backs; a new event beats the grant clear
  logic [NQ-1:0] pend_r;
  logic [NQ-1:0] pend_set;
  logic [NQ-1:0] grant;
  assign pend_set = hwb_on & (tx_desc_done | (throttle_expired & expiry_on));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
    end else begin
      pend_r <= ((pend_r & ~grant) | pend_set) & hwb_on;
    end
  end

  // fixed priority pick, lowest queue first
  // a busy low queue can starve higher ones; write-backs are rare enough
  logic [1:0] pick_q;
  logic       pick_any;
  always_comb begin
    pick_q   = 2'h0;
    pick_any = 1'b0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        pick_q   = 2'(i);
        pick_any = 1'b1;
      end
    end
  end

  // one head write-back in flight at a time
  qwh_wb_state_t wb_state_r;
  qwh_wb_state_t wb_state_nxt;

  // grant only from idle; busy waits for the host to take the request
  always_comb begin
    grant        = '0;
    wb_state_nxt = wb_state_r;
    case (wb_state_r)
      QWH_WB_IDLE: begin
        if (pick_any) begin
          grant[pick_q] = 1'b1;
          wb_state_nxt  = QWH_WB_BUSY;
        end
      end
      QWH_WB_BUSY: begin
        if (dma_wr_ready) begin
          wb_state_nxt = QWH_WB_IDLE;
        end
      end
      default: wb_state_nxt = QWH_WB_IDLE;
    endcase
  end

  // engine state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_state_r <= QWH_WB_IDLE;
    end else begin
      wb_state_r <= wb_state_nxt;
    end
  end

  // one write of the head index per grant, held until the bus takes it
  // addr and data are captured at grant; a later head change waits its turn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_wr_valid <= 1'b0;
      dma_wr_addr  <= 64'h0000_0000_0000_0000;
      dma_wr_data  <= QWH_ZERO32;
    end else if (wb_state_r == QWH_WB_IDLE && pick_any) begin
      dma_wr_valid <= 1'b1;
      dma_wr_addr  <= {comp_hi_r[pick_q], comp_lo_r[pick_q][31:3], 3'b000};
      dma_wr_data  <= 32'(tx_head_index[pick_q*HEAD_W +: HEAD_W]);
    end else if (dma_wr_valid && dma_wr_ready) begin
      dma_wr_valid <= 1'b0;
    end
  end

  // launch time: base plus relative, both in 32 ns steps, shown in ns
  logic [LREL_W:0] launch_sum;
  logic [31:0]     launch_ns_nxt;
  assign launch_sum    = {1'b0, launch_r[QWH_LAUNCH_MSB:QWH_LAUNCH_LSB]} + {1'b0, launch_rel};
  // scaled to ns; the top bit pads the 31-bit product to the port width
  assign launch_ns_nxt = {1'b0, launch_sum, 5'b00000};

  // no wrap check here: software keeps the sum under one second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_valid   <= 1'b0;
      launch_time_ns <= QWH_ZERO32;
    end else begin
      launch_valid <= launch_req;
      if (launch_req) begin
        launch_time_ns <= launch_ns_nxt;
      end
    end
  end

  // header and payload are the only receive data writes
  function automatic logic qwh_data_write(input logic [1:0] k);
    return (k == QWH_RX_HEADER) || (k == QWH_RX_PAYLOAD);
  endfunction

  // receive hint lookup; the fetch path carries no hint value
  logic [31:0] rx_ctl;
  logic        rx_en;
  logic        rx_valued;
  logic        rx_data_wr;
  assign rx_ctl     = rx_queue_hint_control_r[rx_req_queue];
  assign rx_en      = rx_ctl[rx_req_kind];
  // value only on write-back, header and payload; a fetch hint stays bare
  assign rx_valued  = rx_en && (rx_req_kind != QWH_RX_DESC_FETCH);
  assign rx_data_wr = qwh_data_write(rx_req_kind);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_resp_valid <= 1'b0;
      rx_hint_on    <= 1'b0;
      rx_hint_value <= '0;
      rx_no_snoop   <= 1'b0;
    end else begin
      rx_resp_valid <= rx_req;
      if (rx_req) begin
        rx_hint_on    <= rx_en;
        rx_hint_value <= rx_valued ? rx_ctl[QWH_HINT_LSB +: QWH_HINT_W] : '0;
        rx_no_snoop   <= rx_req_nse && rx_data_wr;
      end
    end
  end

endmodule

// ==== design/qwh_pkg.sv ====
// package for the queue write-back and hint configuration block.
// assumes a 32-bit apb slave port and single-clock dma requests.
package qwh_pkg;

  localparam int NQ = 4;                       // transmit and receive queues
  localparam int HEAD_W = 16;                  // head index width
  localparam int LREL_W = 25;                  // relative launch time width

  // register byte offsets
  localparam logic [15:0] QWH_COMP_LO_OFS     = 16'hE038;
  localparam logic [15:0] QWH_COMP_HI_OFS     = 16'hE03C;
  localparam logic [15:0] QWH_COMP_LO_ALIAS   = 16'h3838;
  localparam logic [15:0] QWH_COMP_HI_ALIAS   = 16'h383C;
  localparam logic [15:0] QWH_QUEUE_STRIDE    = 16'h0040;
  localparam logic [15:0] QWH_ALIAS_STRIDE    = 16'h0100;
  localparam logic [15:0] QWH_LAUNCH_OFS      = 16'h3578;
  localparam logic [15:0] QWH_RX_QUEUE_HINT_CONTROL_OFS       = 16'hC014;

  // completion address low word fields
  localparam int QWH_HEAD_WB_ON_BIT   = 0;
  localparam int QWH_WB_EXPIRY_BIT    = 1;

  // launch time base fields and units
  localparam int QWH_LAUNCH_LSB       = 5;
  localparam int QWH_LAUNCH_MSB       = 29;
  localparam int QWH_LAUNCH_RSV_BIT   = 31;
  localparam int QWH_LAUNCH_UNIT_NS   = 32;
  localparam logic [31:0] QWH_LAUNCH_RST = 32'h8000_0000;

  // receive hint control fields
  localparam int QWH_HINT_EN_W        = 4;     // bits 3:0, one per traffic kind
  localparam int QWH_HINT_LSB         = 24;    // target hint field 31:24
  localparam int QWH_HINT_W           = 8;
  localparam logic [31:0] QWH_RX_QUEUE_HINT_CONTROL_MASK = 32'hFF00_000F;

  localparam logic [31:0] QWH_ZERO32  = 32'h0000_0000;

  // receive traffic kinds, also the enable bit index
  typedef enum logic [1:0] {
    QWH_RX_DESC_FETCH = 2'h0,
    QWH_RX_DESC_WB    = 2'h1,
    QWH_RX_HEADER     = 2'h2,
    QWH_RX_PAYLOAD    = 2'h3
  } qwh_rx_kind_t;

  // register groups seen by the decoder
  typedef enum logic [1:0] {
    QWH_REG_COMP_LO = 2'h0,
    QWH_REG_COMP_HI = 2'h1,
    QWH_REG_LAUNCH  = 2'h2,
    QWH_REG_RX_QUEUE_HINT_CONTROL   = 2'h3
  } qwh_reg_t;

  // head write-back engine states, one-hot
  typedef enum logic [1:0] {
    QWH_WB_IDLE = 2'b01,
    QWH_WB_BUSY = 2'b10
  } qwh_wb_state_t;

endpackage

// ==== verif/qwh_host_mem.sv ====
// host memory model answering head write-back requests.
// assumes the request is held until ready is seen high.
`timescale 1ns/1ps
module qwh_host_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_valid,
  input  wire logic [63:0] wr_addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  stall,
  output logic             wr_ready,
  output logic [63:0]      got_addr,
  output logic [31:0]      got_data,
  output int               got_count
);
  logic [3:0] wait_r;
  // ready after stall cycles, one cycle wide so a slow host is exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r    <= 4'h0;
      wr_ready  <= 1'b0;
      got_count <= 0;
    end else if (wr_ready || !wr_valid) begin
      wait_r   <= 4'h0;
      wr_ready <= 1'b0;
      if (wr_ready && wr_valid) begin
        got_addr  <= wr_addr;
        got_data  <= wr_data;
        got_count <= got_count + 1;
      end
    end else if (wait_r == stall) begin
      wr_ready <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ==== verif/qwh_properties.sv ====
// checker for qwh_core, bound to every instance of it.
// assumes one pclk domain and sees only the core's ports.
`timescale 1ns/1ps
module qwh_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  soft_flush_request,
  input wire logic [3:0]  desc_wb_allow,
  input wire logic [3:0]  flush_take,
  input wire logic        dma_wr_valid,
  input wire logic        dma_wr_ready,
  input wire logic [63:0] dma_wr_addr,
  input wire logic [31:0] dma_wr_data,
  input wire logic        launch_req,
  input wire logic        launch_valid,
  input wire logic        rx_req,
  input wire logic [1:0]  rx_req_kind,
  input wire logic        rx_req_nse,
  input wire logic        rx_resp_valid,
  input wire logic        rx_hint_on,
  input wire logic [7:0]  rx_hint_value,
  input wire logic        rx_no_snoop
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states: one ready pulse per setup
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access pulse");
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer carries data");
  a_flush_gate: assert property (flush_take == ($past(soft_flush_request) & desc_wb_allow))
    else $error("flush taken in head mode");
  a_wb_needs_head: assert property ($rose(dma_wr_valid) |-> desc_wb_allow != 4'hF)
    else $error("write-back with head mode off");
  a_wb_hold: assert property (dma_wr_valid && !dma_wr_ready |=> dma_wr_valid &&
    $stable(dma_wr_addr) && $stable(dma_wr_data)) else $error("request not held");
  a_wb_release: assert property (dma_wr_valid && dma_wr_ready |=> !dma_wr_valid)
    else $error("request kept after acceptance");
  a_wb_format: assert property (dma_wr_valid |-> dma_wr_addr[2:0] == 3'h0 &&
    dma_wr_data[31:16] == 16'h0000) else $error("bad write-back address or data");
  a_launch_answer: assert property (launch_req |=> launch_valid)
    else $error("launch answer missing");
  a_rx_snoop: assert property (rx_req |=> rx_resp_valid && rx_no_snoop ==
    ($past(rx_req_nse) && $past(rx_req_kind[1]))) else $error("bad no-snoop answer");
  a_rx_bare: assert property (rx_resp_valid && ($past(rx_req_kind) == 2'h0
    || !rx_hint_on) |-> rx_hint_value == 8'h00) else $error("hint value leaked");
endmodule

bind qwh_core qwh_properties qwh_properties_i (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .prdata, .soft_flush_request, .desc_wb_allow, .flush_take, .dma_wr_valid,
  .dma_wr_ready, .dma_wr_addr, .dma_wr_data, .launch_req, .launch_valid, .rx_req,
  .rx_req_kind, .rx_req_nse, .rx_resp_valid, .rx_hint_on, .rx_hint_value, .rx_no_snoop);

// ==== verif/tb_top.sv ====
// self-checking bench for qwh_core beside a host memory model.
// assumes apb answers without wait states; pclk 40 MHz.
`timescale 1ns/1ps
module tb_top
  import qwh_pkg::*;
();
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, dma_wr_valid, dma_wr_ready;
  logic        launch_req, launch_valid, rx_req, rx_req_nse, rx_resp_valid;
  logic        rx_hint_on, rx_no_snoop;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, dma_wr_data, got_data, launch_time_ns;
  logic [3:0]  tx_desc_done, throttle_expired, soft_flush_request;
  logic [3:0]  desc_wb_allow, flush_take, stall;
  logic [63:0] tx_head_index, dma_wr_addr, got_addr;
  logic [24:0] launch_rel;
  logic [1:0]  rx_req_kind, rx_req_queue;
  logic [7:0]  rx_hint_value;
  int          got_count, bad_count = 0, cmp_count = 0, cycles = 0;

  always #12.5 pclk = ~pclk;

  qwh_core qwh_core_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_desc_done, .throttle_expired, .soft_flush_request,
    .tx_head_index, .desc_wb_allow, .flush_take, .dma_wr_valid, .dma_wr_ready, .dma_wr_addr,
    .dma_wr_data, .launch_req, .launch_rel, .launch_valid, .launch_time_ns, .rx_req,
    .rx_req_kind, .rx_req_queue, .rx_req_nse, .rx_resp_valid, .rx_hint_on, .rx_hint_value,
    .rx_no_snoop);
  qwh_host_mem qwh_host_mem_i (.pclk, .presetn, .wr_valid(dma_wr_valid),
    .wr_addr(dma_wr_addr), .wr_data(dma_wr_data), .stall, .wr_ready(dma_wr_ready),
    .got_addr, .got_data, .got_count);

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 64'h1, 64'(n));
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("write pslverr", 64'h0, 64'(e));
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", 64'(x), 64'(r));
  endtask

  // queue event pulses, one cycle wide
  task automatic pulse(input logic [3:0] done, input logic [3:0] tmr);
    @(posedge pclk);
    tx_desc_done     <= done;
    throttle_expired <= tmr;
    @(posedge pclk);
    tx_desc_done     <= 4'h0;
    throttle_expired <= 4'h0;
  endtask

  // waits for the host write count to reach n1, or watches for none
  task automatic wait_mem(input int n0, input int n1);
    for (int i = 0; i < 30 && got_count == n0 && n1 != n0; i++) @(posedge pclk);
    if (n1 == n0) repeat (12) @(posedge pclk);
    chk("host write count", 64'(n1), 64'(got_count));
  endtask

  task automatic t_regs();
    logic [15:0] lo;
    logic [15:0] al;
    logic [31:0] r;
    logic        e;
    repeat (2) @(posedge pclk); // allow rises one edge after release
    chk("desc_wb_allow", 64'hF, 64'(desc_wb_allow));
    rd(16'h3578, 32'h8000_0000);
    for (int q = 0; q < 4; q++) begin
      lo = 16'hE038 + 16'(q) * 16'h0040;
      al = 16'h3838 + 16'(q) * 16'h0100;
      rd(lo, 32'h0000_0000);
      rd(16'hC014 + 16'(q) * 16'h0040, 32'h0000_0000);
      wr(lo, 32'hA0B0_C000 + 32'(q) * 32'h0000_0100);
      rd(al, 32'hA0B0_C000 + 32'(q) * 32'h0000_0100);
      wr(al + 16'h0004, 32'h1234_0000 + 32'(q));
      rd(lo + 16'h0004, 32'h1234_0000 + 32'(q));
      wr(lo, 32'h0000_0000);
    end
    wr(16'hC014, 32'hFF00_002F);
    rd(16'hC014, 32'hFF00_000F);
    apb(1'b1, 16'h0010, 32'hFFFF_FFFF, r, e);
    chk("unmapped pslverr", 64'h1, 64'(e));
    apb(1'b0, 16'h0010, 32'h0000_0000, r, e);
    chk("unmapped read", 64'h1_0000_0000, {31'h0, e, r});
  endtask

  task automatic t_headwb();
    int n;
    stall <= 4'h3;
    wr(16'hE0BC, 32'h89AB_CDEF);
    wr(16'hE0B8, 32'h1234_567D);
    soft_flush_request <= 4'hF;
    repeat (2) @(posedge pclk);
    chk("desc_wb_allow", 64'hB, 64'(desc_wb_allow));
    chk("flush_take", 64'hB, 64'(flush_take));
    soft_flush_request <= 4'h0;
    tx_head_index <= 64'h0000_00A5_0000_0000;
    n = got_count;
    pulse(4'h4, 4'h0);
    wait_mem(n, n + 1);
    chk("dma addr", 64'h89AB_CDEF_1234_5678, got_addr);
    chk("dma data", 64'h0000_00A5, 64'(got_data));
    pulse(4'h0, 4'h4);
    wait_mem(n + 1, n + 1);
    stall <= 4'h0;
    wr(16'hE0B8, 32'h1234_567F);
    pulse(4'h0, 4'h4);
    wait_mem(n + 1, n + 2);
    wr(16'hE0B8, 32'h1234_5678);
    pulse(4'h4, 4'h0);
    wait_mem(n + 2, n + 2);
  endtask

  task automatic t_launch(input logic [24:0] base, input logic [24:0] rel);
    logic [25:0] s;
    s = 26'(base) + 26'(rel);
    wr(16'h3578, {2'b10, base, 5'h00});
    rd(16'h3578, {2'b10, base, 5'h00});
    @(posedge pclk);
    launch_req <= 1'b1;
    launch_rel <= rel;
    @(posedge pclk);
    launch_req <= 1'b0;
    @(posedge pclk);
    chk("launch_valid", 64'h1, 64'(launch_valid));
    chk("launch_time_ns", 64'({s, 5'h00}), 64'(launch_time_ns));
  endtask

  task automatic t_rx(input logic [1:0] q, input logic [3:0] en, input logic [7:0] h);
    wr(16'hC014 + 16'(q) * 16'h0040, {h, 20'h0_0000, en});
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      rx_req       <= 1'b1;
      rx_req_kind  <= 2'(k);
      rx_req_queue <= q;
      rx_req_nse   <= k[0];
      @(posedge pclk);
      rx_req <= 1'b0;
      @(posedge pclk);
      chk("rx_resp_valid", 64'h1, 64'(rx_resp_valid));
      chk("rx_hint_on", 64'(en[k]), 64'(rx_hint_on));
      chk("rx_hint_value", (en[k] && k != 0) ? 64'(h) : 64'h0, 64'(rx_hint_value));
      chk("rx_no_snoop", 64'(k == 3), 64'(rx_no_snoop));
    end
  endtask

  // cycle ceiling cuts a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 6000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    {psel, penable, pwrite, launch_req, rx_req, rx_req_nse} <= 6'h00;
    {paddr, pwdata, launch_rel, rx_req_kind, rx_req_queue} <= 77'h0;
    {tx_desc_done, throttle_expired, soft_flush_request, stall} <= 16'h0000;
    tx_head_index <= 64'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_headwb();
    t_launch(25'h000_0010, 25'h000_0003);
    t_launch(25'h0F0_0000, 25'h0DC_0000);
    t_rx(2'h1, 4'h5, 8'hA5);
    t_rx(2'h3, 4'hA, 8'h3C);
    finish_test();
  end
endmodule
